// [sssc_pkg.sv]
// Purpose: Shared constants and types for the synchronous SRAM sleep and cycle control
// Assumes: 100 MHz mclk, 18-bit data, 19-bit address
// Notes:   Timing counts derive from the printed clock-period multiples
package sssc_pkg;

    localparam int ADDR_W = 19;
    localparam int DATA_W = 18;
    localparam int DEPTH  = 1 << ADDR_W;

    // Clock period in ns and the sleep timing figures in ns
    localparam int CLK_PERIOD_NS      = 10;
    localparam int SLEEP_ENTRY_MAX_NS = 2 * CLK_PERIOD_NS;
    localparam int SLEEP_EXIT_MAX_NS  = 2 * CLK_PERIOD_NS;
    // Longest times round down, never below one cycle
    localparam int SLEEP_ENTRY_CYC =
        (SLEEP_ENTRY_MAX_NS / CLK_PERIOD_NS) < 1 ? 1 : (SLEEP_ENTRY_MAX_NS / CLK_PERIOD_NS);
    localparam int SLEEP_EXIT_CYC =
        (SLEEP_EXIT_MAX_NS / CLK_PERIOD_NS) < 1 ? 1 : (SLEEP_EXIT_MAX_NS / CLK_PERIOD_NS);

    // Burst ordering strap values
    localparam logic BURST_LINEAR      = 1'b0;
    localparam logic BURST_INTERLEAVED = 1'b1;
    localparam logic [1:0] BURST_START = 2'h0;

    // Sleep state, Gray coded along awake -> sleep -> waking
    typedef enum logic [1:0] {
        SSSC_AWAKE  = 2'b00,
        SSSC_SLEEP  = 2'b01,
        SSSC_WAKING = 2'b11
    } sssc_state_t;

    // One registered command
    typedef struct packed {
        logic              valid;
        logic              write;
        logic [ADDR_W-1:0] addr;
    } sssc_cmd_t;

endpackage

// [sssc_mem.sv]
// Purpose: Single-port memory array with registered read data
// Assumes: One read or one write per cycle
// Notes:   Read data is registered; the core gives a read the port over a pending write
`timescale 1ns/1ps
module sssc_mem
(
    // Clock
    input  wire logic                        mclk,
    // Access
    input  wire logic                        we,
    input  wire logic [sssc_pkg::ADDR_W-1:0] addr,
    input  wire logic [sssc_pkg::DATA_W-1:0] wdata,
    output      logic [sssc_pkg::DATA_W-1:0] rdata
);
    logic [sssc_pkg::DATA_W-1:0] mem [sssc_pkg::DEPTH];

    always_ff @(posedge mclk)
    begin
        if (we)
            mem[addr] <= wdata;
        rdata <= mem[addr];
    end
endmodule

// [sssc_core.sv]
// Purpose: Pipelined synchronous SRAM core with sleep control, burst and coherent writes
// Assumes: Inputs synchronous to mclk; sleep_request sampled asynchronously into a flop
// Notes:   Late write: data follows its command by one cycle and waits in a data register
`timescale 1ns/1ps

// Behaviour
// - In sleep the device is deselected, ignores inputs, and tristates outputs.
// - Sleep request is asynchronous, active high; sleep lasts while it is high.
// - Inputs are ignored within two clock periods of sleep request rising.
// - Synchronous inputs are sampled again within two periods of sleep release.
// - Standby current state is reached within two periods of sleep request.
// - Burst order follows mode strap: low linear, high interleaved.
// - Enabled only when both low selects are low and high select is high.
// - Reads return the newest write, forwarded from the data register if needed.
// - Inactive clock enable stalls the edge; no write happens then.
module sssc_core
(
    // Clock and reset
    input  wire logic                        mclk,
    input  wire logic                        resetn,
    // Power control
    input  wire logic                        sleep_request,
    output      logic                        sleep_standby_current,
    // Command
    input  wire logic                        clock_enable_n,
    input  wire logic                        chip_select_n,
    input  wire logic                        chip_select_second_n,
    input  wire logic                        chip_select_high,
    input  wire logic                        advance_load_n,
    input  wire logic                        read_write_n,
    input  wire logic [sssc_pkg::ADDR_W-1:0] addr,
    input  wire logic                        burst_mode,
    // Data bus, output enable low while driving
    input  wire logic [sssc_pkg::DATA_W-1:0] dq_in,
    output      logic [sssc_pkg::DATA_W-1:0] dq_out,
    output      logic                        dq_oe_n
);
    // ------------------------------------------------------------
    // Sleep control
    // ------------------------------------------------------------
    // Asynchronous set keeps entry immediate; release waits for a clock
    logic                  sleep_r;
    sssc_pkg::sssc_state_t state_r;
    sssc_pkg::sssc_state_t state_nxt;

    always_ff @(posedge mclk or posedge sleep_request or negedge resetn)
    begin
        if (!resetn)
            sleep_r <= 1'b0;
        else if (sleep_request)
            sleep_r <= 1'b1;
        else
            sleep_r <= 1'b0;
    end

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            sssc_pkg::SSSC_AWAKE:  if (sleep_r) state_nxt = sssc_pkg::SSSC_SLEEP;
            sssc_pkg::SSSC_SLEEP:  if (!sleep_r) state_nxt = sssc_pkg::SSSC_WAKING;
            sssc_pkg::SSSC_WAKING: state_nxt = sleep_r ? sssc_pkg::SSSC_SLEEP
                                                       : sssc_pkg::SSSC_AWAKE;
            default:               state_nxt = sssc_pkg::SSSC_AWAKE;
        endcase
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            state_r <= sssc_pkg::SSSC_AWAKE;
        else
            state_r <= state_nxt;
    end

    // Asleep covers the flop as soon as it is set; inputs gated at once
    logic asleep;
    assign asleep = sleep_r || (state_r == sssc_pkg::SSSC_SLEEP);
    assign sleep_standby_current = asleep;

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    logic enabled;
    logic take;
    logic new_cmd;
    assign enabled = !chip_select_n && !chip_select_second_n && chip_select_high;
    // Stalled edges freeze the whole pipeline; sleep clears it
    assign take    = !clock_enable_n && !asleep;
    assign new_cmd = !advance_load_n;

    // ------------------------------------------------------------
    // Pipeline and burst
    // ------------------------------------------------------------
    sssc_pkg::sssc_cmd_t         cmd_r, cmd_nxt;   // Command of this cycle
    logic [1:0]                  cnt_r, cnt_nxt;
    logic                        mode_r, mode_nxt;
    logic [sssc_pkg::ADDR_W-1:0] base_r, base_nxt;
    logic [sssc_pkg::ADDR_W-1:0] wr_addr_r, wr_addr_nxt;
    logic [sssc_pkg::DATA_W-1:0] wr_data_r, wr_data_nxt;
    logic                        wr_pend_r, wr_pend_nxt;
    logic                        hold_r, hold_nxt;
    logic [sssc_pkg::DATA_W-1:0] hold_data_r, hold_data_nxt;
    logic [sssc_pkg::DATA_W-1:0] q_sel;
    logic                        fwd_r, fwd_nxt;
    logic [sssc_pkg::DATA_W-1:0] fwd_data_r, fwd_data_nxt;
    logic                        oe_r, oe_nxt;
    logic [1:0]                  burst_ofs;
    logic [sssc_pkg::DATA_W-1:0] mem_rdata;
    logic                        mem_we;
    logic [sssc_pkg::ADDR_W-1:0] mem_addr;

    always_comb
    begin
        cnt_nxt      = cnt_r;
        mode_nxt     = mode_r;
        base_nxt     = base_r;
        cmd_nxt      = cmd_r;
        wr_addr_nxt  = wr_addr_r;
        wr_data_nxt  = wr_data_r;
        wr_pend_nxt  = wr_pend_r;
        hold_nxt      = hold_r;
        hold_data_nxt = hold_data_r;
        fwd_nxt      = fwd_r;
        fwd_data_nxt = fwd_data_r;
        oe_nxt       = oe_r;
        burst_ofs    = 2'h0;
        if (asleep)
        begin
            // Deselect everything; pending work is dropped
            cmd_nxt     = '0;
            wr_pend_nxt = 1'b0;
            hold_nxt    = 1'b0;
            oe_nxt      = 1'b0;
        end
        else if (take)
        begin
            // Burst address from start offset and counter
            if (new_cmd)
            begin
                cnt_nxt  = sssc_pkg::BURST_START;
                base_nxt = addr;
                mode_nxt = burst_mode;
                cmd_nxt.valid = enabled;
                cmd_nxt.write = !read_write_n;
                cmd_nxt.addr  = addr;
            end
            else if (cmd_r.valid)
            begin
                cnt_nxt = cnt_r + 2'h1;
                if (mode_r == sssc_pkg::BURST_INTERLEAVED)
                    burst_ofs = base_r[1:0] ^ cnt_nxt;
                else
                    burst_ofs = base_r[1:0] + cnt_nxt;
                cmd_nxt.addr = {base_r[sssc_pkg::ADDR_W-1:2], burst_ofs};
            end
            hold_nxt = 1'b0;
            // Data of a write arrives one cycle after its command
            if (cmd_r.valid && cmd_r.write)
            begin
                wr_addr_nxt = cmd_r.addr;
                wr_data_nxt = dq_in;
                wr_pend_nxt = 1'b1;
            end
            else if (mem_we)
                wr_pend_nxt = 1'b0;
            // Only the data register can hold data newer than the array
            fwd_nxt = 1'b0;
            if (wr_pend_r && wr_addr_r == cmd_r.addr)
            begin
                fwd_nxt      = 1'b1;
                fwd_data_nxt = wr_data_r;
            end
            // Drive starts in the cycle the registered array data stands
            oe_nxt = cmd_r.valid && !cmd_r.write;
        end
        else
        begin
            // The array port re-reads on a stall, so the bus keeps a copy
            hold_nxt = 1'b1;
            if (!hold_r)
                hold_data_nxt = q_sel;
        end
    end

    // Pending write drains in any cycle the port is free and the edge is taken
    assign mem_we   = take && wr_pend_r && !(cmd_r.valid && !cmd_r.write);
    assign mem_addr = mem_we ? wr_addr_r : cmd_r.addr;

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            cnt_r      <= 2'h0;
            mode_r     <= 1'b0;
            base_r     <= '0;
            cmd_r      <= '0;
            wr_addr_r  <= '0;
            wr_data_r  <= '0;
            wr_pend_r  <= 1'b0;
            hold_r     <= 1'b0;
            hold_data_r <= '0;
            fwd_r      <= 1'b0;
            fwd_data_r <= '0;
            oe_r       <= 1'b0;
        end
        else
        begin
            cnt_r      <= cnt_nxt;
            mode_r     <= mode_nxt;
            base_r     <= base_nxt;
            cmd_r      <= cmd_nxt;
            wr_addr_r  <= wr_addr_nxt;
            wr_data_r  <= wr_data_nxt;
            wr_pend_r  <= wr_pend_nxt;
            hold_r     <= hold_nxt;
            hold_data_r <= hold_data_nxt;
            fwd_r      <= fwd_nxt;
            fwd_data_r <= fwd_data_nxt;
            oe_r       <= oe_nxt;
        end
    end

    sssc_mem u_mem
    (
        .mclk  (mclk),
        .we    (mem_we),
        .addr  (mem_addr),
        .wdata (wr_data_r),
        .rdata (mem_rdata)
    );

    // ------------------------------------------------------------
    // Output drive
    // ------------------------------------------------------------
    assign q_sel   = fwd_r ? fwd_data_r : mem_rdata;
    assign dq_out  = hold_r ? hold_data_r : q_sel;
    assign dq_oe_n = !(oe_r && !asleep);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_sleep_rise;
        $rose(sleep_request);
    endsequence

    AST_SLEEP_OFF: assert property (@(posedge mclk) disable iff (!resetn)
        sleep_r |-> dq_oe_n && !mem_we)
        else $error("Outputs or array active while asleep");
    AST_SLEEP_LEVEL: assert property (@(posedge mclk) disable iff (!resetn)
        sleep_request |-> sleep_r)
        else $error("Sleep flop not following request");
    AST_ENTRY_TIME: assert property (@(posedge mclk) disable iff (!resetn)
        s_sleep_rise |-> ##[0:2] !take)
        else $error("Inputs still taken two cycles after sleep request");
    AST_EXIT_TIME: assert property (@(posedge mclk) disable iff (!resetn)
        $fell(sleep_request) ##0 (!sleep_request)[*3] |-> !asleep)
        else $error("Inputs not sampled two cycles after wake");
    AST_STANDBY: assert property (@(posedge mclk) disable iff (!resetn)
        s_sleep_rise |-> ##[0:2] sleep_standby_current)
        else $error("Standby not reached within two cycles");
    AST_SELECT: assert property (@(posedge mclk) disable iff (!resetn)
        (take && new_cmd && !enabled) |=> !cmd_r.valid)
        else $error("Command accepted without full chip select");
    AST_STALL: assert property (@(posedge mclk) disable iff (!resetn)
        (clock_enable_n && !asleep) |-> !mem_we ##1 $stable(cmd_r))
        else $error("Stalled edge changed state or wrote");
    AST_HOLD: assert property (@(posedge mclk) disable iff (!resetn)
        (clock_enable_n && !asleep && !dq_oe_n) |=> $stable(dq_out))
        else $error("Driven data changed on a stalled edge");
    AST_KIND: assert property (@(posedge mclk) disable iff (!resetn)
        (take && new_cmd && enabled) |=> cmd_r.write == !$past(read_write_n))
        else $error("Command kind not decoded from read/write");
    AST_WAKE_OFF: assert property (@(posedge mclk) disable iff (!resetn)
        $fell(asleep) |-> dq_oe_n)
        else $error("Outputs driven at wake");
    AST_FWD: assert property (@(posedge mclk) disable iff (!resetn)
        (take && cmd_r.valid && !cmd_r.write && wr_pend_r && wr_addr_r == cmd_r.addr)
        |=> fwd_r && fwd_data_r == $past(wr_data_r))
        else $error("Read missed pending write data");
    AST_BURST: assert property (@(posedge mclk) disable iff (!resetn)
        (take && !new_cmd && cmd_r.valid && mode_r == sssc_pkg::BURST_INTERLEAVED)
        |=> cmd_r.addr[1:0] == (2'($past(base_r)) ^ ($past(cnt_r) + 2'h1)))
        else $error("Interleaved burst address wrong");
endmodule

// [sssc_ctl_model.sv]
// Purpose: Controller model that drives the SRAM core pins
// Assumes: Pins change 1 ns after the rising edge of mclk
// Notes:   Write data follows its command on the next unstalled cycle
`timescale 1ns/1ps
module sssc_ctl_model
(
    // Clock
    input  wire logic                        mclk,
    // Pins toward the device
    output      logic                        sleep_request,
    output      logic                        clock_enable_n,
    output      logic                        chip_select_n,
    output      logic                        chip_select_second_n,
    output      logic                        chip_select_high,
    output      logic                        advance_load_n,
    output      logic                        read_write_n,
    output      logic [sssc_pkg::ADDR_W-1:0] addr,
    output      logic                        burst_mode,
    output      logic [sssc_pkg::DATA_W-1:0] dq_in
);
    logic                        pend_v = 1'b0;
    logic [sssc_pkg::DATA_W-1:0] pend_d = 18'h0;

    initial
    begin
        {sleep_request, clock_enable_n, advance_load_n, read_write_n, burst_mode} = 5'h02;
        {chip_select_n, chip_select_second_n, chip_select_high} = 3'h4;
        addr = 19'h0;
        dq_in = 18'h0;
    end

    // One pin cycle; the data bus is never left showing stale data
    task automatic cycle(input logic cke_n, input logic [2:0] cs, input logic adv_n,
                         input logic rw_n, input logic [sssc_pkg::ADDR_W-1:0] a,
                         input logic mode, input logic [sssc_pkg::DATA_W-1:0] d);
        @(posedge mclk);
        #1;
        clock_enable_n = cke_n;
        {chip_select_n, chip_select_second_n, chip_select_high} = cs;
        advance_load_n = adv_n;
        read_write_n = rw_n;
        addr = a;
        burst_mode = mode;
        dq_in = (pend_v && !cke_n) ? pend_d : ~dq_in;
        if (!cke_n)
            pend_v = 1'b0;
        if (!cke_n && !sleep_request && cs == 3'h1 && !adv_n && !rw_n)
        begin
            pend_v = 1'b1;
            pend_d = d;
        end
    endtask

    // Called only while nothing is in flight
    task automatic set_sleep(input logic v);
        @(posedge mclk);
        #1;
        sleep_request = v;
    endtask
endmodule

// [testbench.sv]
// Purpose: Self-checking bench for the SRAM sleep and cycle control core
// Assumes: Reads answer two taken edges after their command
// Notes:   Expected read data queued at issue, popped when the bus drives
`timescale 1ns/1ps
module testbench;
    localparam logic [2:0] SEL = 3'h1;
    logic                        mclk;
    logic                        resetn;
    logic                        sleep_request;
    logic                        sleep_standby_current;
    logic                        clock_enable_n;
    logic                        chip_select_n;
    logic                        chip_select_second_n;
    logic                        chip_select_high;
    logic                        advance_load_n;
    logic                        read_write_n;
    logic [sssc_pkg::ADDR_W-1:0] addr;
    logic                        burst_mode;
    logic [sssc_pkg::DATA_W-1:0] dq_in;
    logic [sssc_pkg::DATA_W-1:0] dq_out;
    logic                        dq_oe_n;
    logic [sssc_pkg::DATA_W-1:0] exp_q[$];
    logic [sssc_pkg::DATA_W-1:0] shadow[int];
    logic                        edge_live = 1'b0;
    logic [sssc_pkg::DATA_W-1:0] last_q = '0;
    int                          err_total = 0;
    int                          tests_run = 0;
    int                          cycles = 0;
    logic [31:0]                 rng = 32'h000135bc;

    sssc_core sssc_core_inst (.mclk, .resetn, .sleep_request, .sleep_standby_current,
        .clock_enable_n, .chip_select_n, .chip_select_second_n, .chip_select_high,
        .advance_load_n, .read_write_n, .addr, .burst_mode, .dq_in, .dq_out, .dq_oe_n);
    sssc_ctl_model sssc_ctl_model_inst (.mclk, .sleep_request, .clock_enable_n,
        .chip_select_n, .chip_select_second_n, .chip_select_high, .advance_load_n,
        .read_write_n, .addr, .burst_mode, .dq_in);

    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic step();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic wr(input logic [sssc_pkg::ADDR_W-1:0] a, input logic [17:0] d);
        shadow[a] = d;
        sssc_ctl_model_inst.cycle(1'b0, SEL, 1'b0, 1'b0, a, 1'b0, d);
    endtask

    task automatic rd(input logic [sssc_pkg::ADDR_W-1:0] a);
        exp_q.push_back(shadow[a]);
        sssc_ctl_model_inst.cycle(1'b0, SEL, 1'b0, 1'b1, a, 1'b0, 18'h0);
    endtask

    task automatic idle(input int n);
        repeat (n) sssc_ctl_model_inst.cycle(1'b0, 3'h4, 1'b0, 1'b1, 19'h0, 1'b0, 18'h0);
    endtask

    // ------------------------------------------------------------
    // Output watcher and hang guard
    // ------------------------------------------------------------
    always @(posedge mclk)
        edge_live = (clock_enable_n === 1'b0);

    // Held data across a stall is not a new result, so only taken edges pop
    always @(negedge mclk)
    begin
        if (resetn === 1'b1 && dq_oe_n === 1'b0)
        begin
            if (!edge_live)
                check("held data", dq_out, last_q);
            else if (exp_q.size() == 0)
                check("unexpected drive", 32'h1, 32'h0);
            else
            begin
                last_q = exp_q.pop_front();
                check("read data", dq_out, last_q);
            end
        end
    end

    always @(posedge mclk)
    begin
        cycles++;
        if (cycles > 3000)
        begin
            err_total++;
            finish_test();
        end
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial
    begin
        logic [sssc_pkg::ADDR_W-1:0] a;
        logic [sssc_pkg::ADDR_W-1:0] list[8];
        logic [1:0]                  off;
        resetn = 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        resetn = 1'b1;
        for (int i = 0; i < 8; i++)
        begin
            step();
            list[i] = rng[sssc_pkg::ADDR_W-1:0];
            wr(list[i], rng[31:14]);
        end
        for (int i = 0; i < 8; i++)
            rd(list[i]);
        // Newest write must win even before it reaches the array
        step();
        a = rng[sssc_pkg::ADDR_W-1:0];
        wr(a, rng[31:14]);
        wr(a, ~rng[31:14]);
        rd(a);
        wr(a, rng[17:0]);
        rd(a);
        idle(3);
        // Stalled write is dropped; stalled read is ignored; data holds over stalls
        sssc_ctl_model_inst.cycle(1'b1, SEL, 1'b0, 1'b0, list[0], 1'b0, 18'h2aaa5);
        idle(1);
        rd(list[0]);
        idle(1);
        repeat (2) sssc_ctl_model_inst.cycle(1'b1, SEL, 1'b0, 1'b1, list[1], 1'b0, 18'h0);
        idle(3);
        for (int c = 0; c < 8; c++)
            if (c != 1)
            begin
                sssc_ctl_model_inst.cycle(1'b0, c[2:0], 1'b0, 1'b0, list[1], 1'b0, 18'h15a5a);
                sssc_ctl_model_inst.cycle(1'b0, c[2:0], 1'b0, 1'b1, list[1], 1'b0, 18'h0);
            end
        rd(list[1]);
        idle(3);
        // Burst from offset 1, where the two orders differ; strap latched at start
        for (int m = 0; m < 2; m++)
        begin
            step();
            for (int i = 0; i < 4; i++)
                wr({rng[18:2], i[1:0]}, rng[31:14] ^ 18'(i));
            exp_q.push_back(shadow[{rng[18:2], 2'h1}]);
            sssc_ctl_model_inst.cycle(1'b0, SEL, 1'b0, 1'b1, {rng[18:2], 2'h1}, m[0], 18'h0);
            for (int i = 1; i < 4; i++)
            begin
                off = m[0] ? (2'h1 ^ i[1:0]) : (2'h1 + i[1:0]);
                exp_q.push_back(shadow[{rng[18:2], off}]);
                sssc_ctl_model_inst.cycle(1'b0, SEL, 1'b1, 1'b1, 19'h0, !m[0], 18'h0);
            end
            idle(3);
        end
        sssc_ctl_model_inst.set_sleep(1'b1);
        repeat (2) @(posedge mclk);
        #2;
        check("standby", sleep_standby_current, 32'h1);
        check("output off", dq_oe_n, 32'h1);
        sssc_ctl_model_inst.cycle(1'b0, SEL, 1'b0, 1'b0, list[2], 1'b0, 18'h0f0f0);
        sssc_ctl_model_inst.cycle(1'b0, SEL, 1'b0, 1'b1, list[2], 1'b0, 18'h0);
        #2;
        check("standby held", sleep_standby_current, 32'h1);
        sssc_ctl_model_inst.set_sleep(1'b0);
        idle(2);
        rd(list[2]);
        idle(3);
        check("standby left", sleep_standby_current, 32'h0);
        check("reads left", exp_q.size(), 32'h0);
        finish_test();
    end
endmodule
